// ---- rtl/autoneg_next_page_regs.sv ----
/*
 * Auto-negotiation expansion, next-page transmit and next-page receive
 * registers, plus the partner base-page register store.
 * Assumes a synchronous single-cycle management port and an engine that
 * reports received pages and sent pages as one-cycle pulses.
 */
`timescale 1ns/100ps
module autoneg_next_page_regs (
    input wire logic I_CLOCK,                 // 50 MHz clock.
    input wire logic I_SRST,                  // Synchronous reset, high.
    input wire an_np_pkg::mgmt_req_s I_REQ,   // Management request.
    input wire an_np_pkg::an_event_s I_EVT,   // Engine events.
    output logic [15:0] O_RDATA,              // Read data, registered.
    output logic O_RVALID,                    // Read data valid pulse.
    output logic [15:0] O_TX_PAGE             // Page word to send.
);
    // Register state, its next values and the assembled expansion word.
    logic [15:0] tx_word;
    logic [15:0] rx_word;
    logic [15:0] base_word;
    logic lp_an_able;
    logic toggle;
    logic [15:0] next_tx_word;
    logic [15:0] next_rx_word;
    logic [15:0] next_base_word;
    logic next_lp_an_able;
    logic next_toggle;
    logic [15:0] next_rdata;
    logic next_rvalid;
    logic pd_flag;
    logic prx_flag;
    logic exp_read;
    logic [15:0] exp_word;

    // Any expansion read, whatever its answer, clears the latched flags.
    assign exp_read = I_REQ.rd && (I_REQ.idx == an_np_pkg::IDX_EXPANSION);

    // Latch-high flags; a present cause re-sets the flag over the clear.
    latch_high_flag u_pd_fault (
        .i_clk(I_CLOCK),
        .i_srst(I_SRST),
        .i_event(I_EVT.pd_fault),
        .i_read(exp_read),
        .o_flag(pd_flag)
    );
    latch_high_flag u_page_rx (
        .i_clk(I_CLOCK),
        .i_srst(I_SRST),
        .i_event(I_EVT.page_rx),
        .i_read(exp_read),
        .o_flag(prx_flag)
    );

    // Expansion word assembled from constants and live state.
    always_comb begin
        exp_word = an_np_pkg::RSVD_ZERO;
        exp_word[an_np_pkg::EXP_LOC_ABLE] = 1'b1;
        exp_word[an_np_pkg::EXP_LOC_SEL] = 1'b1;
        exp_word[an_np_pkg::EXP_PD_FAULT] = pd_flag;
        exp_word[an_np_pkg::EXP_LP_NP_ABLE] =
            base_word[an_np_pkg::NP_NEXT];
        exp_word[an_np_pkg::EXP_NP_ABLE] = 1'b1;
        exp_word[an_np_pkg::EXP_PAGE_RX] = prx_flag;
        exp_word[an_np_pkg::EXP_LP_AN_ABLE] = lp_an_able;
    end

    // Page stores. Because bit 5 is fixed at 1, next pages only ever go
    // to the receive register and the base page store keeps base pages.
    always_comb begin
        next_tx_word = tx_word;
        next_rx_word = rx_word;
        next_base_word = base_word;
        next_lp_an_able = lp_an_able || I_EVT.lp_an_able;
        next_toggle = toggle;
        if (I_REQ.wr && (I_REQ.idx == an_np_pkg::IDX_NP_TRANSMIT)) begin
            next_tx_word = I_REQ.wdata & an_np_pkg::TX_WRITE_MASK;
        end
        if (I_EVT.page_rx && I_EVT.is_base) begin
            next_base_word = I_EVT.page;
        end
        if (I_EVT.page_rx && !I_EVT.is_base) begin
            next_rx_word = I_EVT.page;
            next_rx_word[an_np_pkg::NP_ACK] = 1'b1;
        end
        if (I_EVT.page_sent) begin
            next_toggle = ~O_TX_PAGE[an_np_pkg::NP_TOGGLE];
        end
    end

    // Register the page stores; partner ability drops only on reset.
    always_ff @(posedge I_CLOCK) begin
        if (I_SRST) begin
            tx_word <= an_np_pkg::TX_RESET;
            rx_word <= an_np_pkg::RX_RESET;
            base_word <= an_np_pkg::BASE_RESET;
            lp_an_able <= 1'b0;
            toggle <= 1'b0;
        end else begin
            tx_word <= next_tx_word;
            rx_word <= next_rx_word;
            base_word <= next_base_word;
            lp_an_able <= next_lp_an_able;
            toggle <= next_toggle;
        end
    end

    // Read mux; writes to read-only registers are ignored silently.
    always_comb begin
        next_rvalid = I_REQ.rd;
        next_rdata = an_np_pkg::RSVD_ZERO;
        if (I_REQ.rd) begin
            unique case (I_REQ.idx)
                an_np_pkg::IDX_PARTNER_BASE: next_rdata = base_word;
                an_np_pkg::IDX_EXPANSION: next_rdata = exp_word;
                an_np_pkg::IDX_NP_TRANSMIT: begin
                    next_rdata = tx_word;
                    next_rdata[an_np_pkg::NP_TOGGLE] = toggle;
                end
                an_np_pkg::IDX_NP_RECEIVE: next_rdata = rx_word;
                default: next_rdata = an_np_pkg::RSVD_ZERO;
            endcase
        end
    end

    // Outputs come straight from flip-flops.
    always_ff @(posedge I_CLOCK) begin
        if (I_SRST) begin
            O_RDATA <= an_np_pkg::RSVD_ZERO;
            O_RVALID <= 1'b0;
            O_TX_PAGE <= an_np_pkg::TX_RESET;
        end else begin
            O_RDATA <= next_rdata;
            O_RVALID <= next_rvalid;
            O_TX_PAGE <= {next_tx_word[15:12], next_toggle,
                          next_tx_word[10:0]};
        end
    end

    // Expansion read data: reserved zeros above bit 6, fixed ones in
    // bits 6, 5 and 2, so software can rely on the layout.
    a_exp_const: assert property (
        @(posedge I_CLOCK) disable iff (I_SRST)
        exp_read |=> O_RDATA[15:5] == 11'h003)
        else $error("expansion constant bits wrong");
    a_exp_loc_able: assert property (
        @(posedge I_CLOCK) disable iff (I_SRST)
        exp_read |=> O_RDATA[an_np_pkg::EXP_LOC_ABLE])
        else $error("storage location able bit not set");
    a_exp_loc_sel: assert property (
        @(posedge I_CLOCK) disable iff (I_SRST)
        exp_read |=> O_RDATA[an_np_pkg::EXP_LOC_SEL])
        else $error("storage location bit not set");
    a_exp_np_able: assert property (
        @(posedge I_CLOCK) disable iff (I_SRST)
        exp_read |=> O_RDATA[an_np_pkg::EXP_NP_ABLE])
        else $error("local next page bit not set");

    // Latch-high flags: an event shows on the next read, a flag holds
    // until read, and a read with no cause pending clears it.
    a_pd_seen: assert property (
        @(posedge I_CLOCK) disable iff (I_SRST)
        I_EVT.pd_fault ##1 exp_read |=> O_RDATA[4])
        else $error("fault flag lost");
    a_prx_seen: assert property (
        @(posedge I_CLOCK) disable iff (I_SRST)
        I_EVT.page_rx ##1 exp_read |=> O_RDATA[1])
        else $error("page received flag lost");
    a_pd_live: assert property (
        @(posedge I_CLOCK) disable iff (I_SRST)
        exp_read |=> O_RDATA[4] == $past(pd_flag))
        else $error("fault flag not on read path");
    a_prx_live: assert property (
        @(posedge I_CLOCK) disable iff (I_SRST)
        exp_read |=> O_RDATA[1] == $past(prx_flag))
        else $error("page flag not on read path");
    a_pd_hold: assert property (
        @(posedge I_CLOCK) disable iff (I_SRST)
        pd_flag && !exp_read |=> pd_flag)
        else $error("fault flag dropped without a read");
    a_prx_hold: assert property (
        @(posedge I_CLOCK) disable iff (I_SRST)
        prx_flag && !exp_read |=> prx_flag)
        else $error("page flag dropped without a read");
    a_prx_clear: assert property (
        @(posedge I_CLOCK) disable iff (I_SRST)
        exp_read && !I_EVT.page_rx ##1 exp_read && !I_EVT.page_rx
        |=> !O_RDATA[1])
        else $error("flag not cleared by read");
    a_pd_clear: assert property (
        @(posedge I_CLOCK) disable iff (I_SRST)
        exp_read && !I_EVT.pd_fault ##1 exp_read |=> !O_RDATA[4])
        else $error("fault flag not cleared by read");

    // Partner abilities: next-page ability follows the stored base page,
    // negotiation ability stays set once seen until the next reset.
    a_lp_np: assert property (
        @(posedge I_CLOCK) disable iff (I_SRST)
        exp_read |=> O_RDATA[3] == $past(base_word[15]))
        else $error("partner next page ability wrong");
    a_lp_an: assert property (
        @(posedge I_CLOCK) disable iff (I_SRST)
        I_EVT.lp_an_able ##1 exp_read |=> O_RDATA[0])
        else $error("partner ability not shown");
    a_lp_an_sticky: assert property (
        @(posedge I_CLOCK) disable iff (I_SRST)
        lp_an_able |=> lp_an_able)
        else $error("partner ability dropped");

    // Page stores: each kind of page lands in its own register only, the
    // acknowledge bit rises with the first stored next page and stays.
    a_rx_ack: assert property (
        @(posedge I_CLOCK) disable iff (I_SRST)
        I_EVT.page_rx && !I_EVT.is_base |=> rx_word[14])
        else $error("receive acknowledge not set");
    a_rx_ack_hold: assert property (
        @(posedge I_CLOCK) disable iff (I_SRST)
        rx_word[an_np_pkg::NP_ACK] |=> rx_word[an_np_pkg::NP_ACK])
        else $error("receive acknowledge dropped");
    a_rx_store: assert property (
        @(posedge I_CLOCK) disable iff (I_SRST)
        I_EVT.page_rx && !I_EVT.is_base
        |=> rx_word[13:0] == $past(I_EVT.page[13:0]))
        else $error("receive page not stored");
    a_rx_stable: assert property (
        @(posedge I_CLOCK) disable iff (I_SRST)
        !(I_EVT.page_rx && !I_EVT.is_base) |=> $stable(rx_word))
        else $error("receive word changed without a next page");
    a_base_stable: assert property (
        @(posedge I_CLOCK) disable iff (I_SRST)
        !(I_EVT.page_rx && I_EVT.is_base) |=> $stable(base_word))
        else $error("base page store changed without a base page");
    a_rx_read: assert property (
        @(posedge I_CLOCK) disable iff (I_SRST)
        I_REQ.rd && I_REQ.idx == an_np_pkg::IDX_NP_RECEIVE
        |=> O_RDATA == $past(rx_word))
        else $error("receive word not on read path");
    a_base_read: assert property (
        @(posedge I_CLOCK) disable iff (I_SRST)
        I_REQ.rd && I_REQ.idx == an_np_pkg::IDX_PARTNER_BASE
        |=> O_RDATA == $past(base_word))
        else $error("base page not on read path");

    // Transmit word: writes land masked, bit 14 never shows, the word
    // holds between writes, and the toggle flips once per sent page.
    a_tx_write: assert property (
        @(posedge I_CLOCK) disable iff (I_SRST)
        I_REQ.wr && I_REQ.idx == an_np_pkg::IDX_NP_TRANSMIT
        |=> O_TX_PAGE[10:0] == $past(I_REQ.wdata[10:0])
            && !O_TX_PAGE[14])
        else $error("transmit word write lost");
    a_tx_flags: assert property (
        @(posedge I_CLOCK) disable iff (I_SRST)
        I_REQ.wr && I_REQ.idx == an_np_pkg::IDX_NP_TRANSMIT
        |=> O_TX_PAGE[15] == $past(I_REQ.wdata[15])
            && O_TX_PAGE[13:12] == $past(I_REQ.wdata[13:12]))
        else $error("transmit flag bits not written");
    a_tx_rsvd: assert property (
        @(posedge I_CLOCK) disable iff (I_SRST)
        !O_TX_PAGE[an_np_pkg::NP_ACK])
        else $error("transmit reserved bit set");
    a_tx_hold: assert property (
        @(posedge I_CLOCK) disable iff (I_SRST)
        !(I_REQ.wr && I_REQ.idx == an_np_pkg::IDX_NP_TRANSMIT)
            && !I_EVT.page_sent |=> $stable(O_TX_PAGE))
        else $error("transmit word changed on its own");
    a_toggle_flip: assert property (
        @(posedge I_CLOCK) disable iff (I_SRST)
        I_EVT.page_sent |=> O_TX_PAGE[11] != $past(O_TX_PAGE[11]))
        else $error("toggle did not invert");
    a_toggle_hold: assert property (
        @(posedge I_CLOCK) disable iff (I_SRST)
        !I_EVT.page_sent |=> $stable(toggle))
        else $error("toggle changed without a sent page");
    a_tx_read: assert property (
        @(posedge I_CLOCK) disable iff (I_SRST)
        I_REQ.rd && !I_REQ.wr && !I_EVT.page_sent
            && I_REQ.idx == an_np_pkg::IDX_NP_TRANSMIT
        |=> O_RDATA == O_TX_PAGE)
        else $error("transmit read differs from sent word");

    // Main scenarios: reads, next pages, sent pages, a set racing a
    // clear, and a parallel detection fault.
    c_exp_read: cover property (@(posedge I_CLOCK) exp_read);
    c_np_rx: cover property (@(posedge I_CLOCK)
        I_EVT.page_rx && !I_EVT.is_base);
    c_tx_sent: cover property (@(posedge I_CLOCK) I_EVT.page_sent);
    c_set_clear: cover property (@(posedge I_CLOCK)
        exp_read && I_EVT.page_rx);
    c_pd_fault: cover property (@(posedge I_CLOCK) I_EVT.pd_fault);
endmodule : autoneg_next_page_regs

// ---- inc/an_np_pkg.sv ----
/*
 * Package for the auto-negotiation next-page register bank: register
 * indices, field positions, reset values and the carrier structs.
 * Assumes a 16-bit management register port with 5-bit register index.
 */
package an_np_pkg;

    // Register indices on the management port.
    localparam logic [4:0] IDX_PARTNER_BASE = 5'h05;
    localparam logic [4:0] IDX_EXPANSION = 5'h06;
    localparam logic [4:0] IDX_NP_TRANSMIT = 5'h07;
    localparam logic [4:0] IDX_NP_RECEIVE = 5'h08;

    // Expansion field positions.
    localparam int EXP_LOC_ABLE = 6;
    localparam int EXP_LOC_SEL = 5;
    localparam int EXP_PD_FAULT = 4;
    localparam int EXP_LP_NP_ABLE = 3;
    localparam int EXP_NP_ABLE = 2;
    localparam int EXP_PAGE_RX = 1;
    localparam int EXP_LP_AN_ABLE = 0;

    // Page word field positions.
    localparam int NP_NEXT = 15;
    localparam int NP_ACK = 14;
    localparam int NP_MSG = 13;
    localparam int NP_ACK2 = 12;
    localparam int NP_TOGGLE = 11;
    localparam int NP_CODE_MSB = 10;

    // Reset values; the transmit value carries message page and code 1.
    localparam logic [15:0] TX_RESET = 16'h2001;
    localparam logic [15:0] RX_RESET = 16'h0000;
    localparam logic [15:0] BASE_RESET = 16'h0000;
    localparam logic [15:0] TX_WRITE_MASK = 16'hB7FF;
    localparam logic [15:0] RSVD_ZERO = 16'h0000;

    // Management access request.
    typedef struct packed {
        logic rd;
        logic wr;
        logic [4:0] idx;
        logic [15:0] wdata;
    } mgmt_req_s;

    // Events and levels from the negotiation engine.
    typedef struct packed {
        logic page_rx;
        logic [15:0] page;
        logic is_base;
        logic pd_fault;
        logic lp_an_able;
        logic page_sent;
    } an_event_s;

endpackage : an_np_pkg

// ---- rtl/latch_high_flag.sv ----
/*
 * One latch-high status flag with clear-on-read.
 * Assumes the read strobe is one cycle per register read.
 */
`timescale 1ns/100ps
module latch_high_flag (
    input wire logic i_clk,   // Clock.
    input wire logic i_srst,  // Synchronous reset, active high.
    input wire logic i_event, // Causing condition, level or pulse.
    input wire logic i_read,  // Register read strobe.
    output logic o_flag       // Latched flag.
);
    logic next_flag;

    // A set wins over the read clear so no event is lost.
    always_comb begin
        next_flag = o_flag;
        if (i_read) begin
            next_flag = 1'b0;
        end
        if (i_event) begin
            next_flag = 1'b1;
        end
    end

    // Register only.
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_flag <= 1'b0;
        end else begin
            o_flag <= next_flag;
        end
    end

    // A cause in the read cycle must leave the flag set afterwards.
    a_set_wins: assert property (@(posedge i_clk) disable iff (i_srst)
        i_event |=> o_flag) else $error("flag missed an event");
endmodule : latch_high_flag

// ---- verif/an_partner_model.sv ----
/*
 * Behavioural link partner that feeds negotiation events to the register
 * bank. It assumes the bench calls its task from one process, and that
 * inputs change on the falling edge of the shared clock.
 */
`timescale 1ns/100ps
module an_partner_model (
    input wire logic i_clk,            // Clock shared with the device.
    output an_np_pkg::an_event_s o_evt // Events toward the device.
);
    // Everything idle at time zero so the device never sees unknowns.
    initial begin
        o_evt = '0;
    end

    // Present one event word for a single cycle, then release the lines.
    // The released page bus shows the inverse of the last page, so a
    // device that samples it late picks up junk rather than a lucky match.
    task automatic pulse(input an_np_pkg::an_event_s e);
        an_np_pkg::an_event_s idle;
        idle = '0;
        idle.page = ~e.page;
        @(negedge i_clk);
        o_evt = e;
        @(negedge i_clk);
        o_evt = idle;
    endtask : pulse
endmodule : an_partner_model

// ---- verif/test_autoneg_next_page_regs.sv ----
/*
 * Self-checking bench for the next-page register bank: a table of plain
 * register accesses, then event, toggle, clear-on-read and reset cases.
 * Assumes the partner model and a single 50 MHz clock domain.
 */
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin \
    checks_done++; \
    if ((got) !== (ex)) begin \
        miscompares++; \
        $display("MISMATCH %s expected %h seen %h", nm, ex, got); \
    end \
end
module test_autoneg_next_page_regs;
    typedef struct packed {
        logic wr;
        logic [4:0] idx;
        logic [15:0] wdata;
        logic [15:0] exp;
    } row_s;
    logic I_CLOCK;
    logic I_SRST;
    an_np_pkg::mgmt_req_s I_REQ;
    an_np_pkg::an_event_s I_EVT;
    logic [15:0] O_RDATA;
    logic O_RVALID;
    logic [15:0] O_TX_PAGE;
    int miscompares = 0;
    int checks_done = 0;
    // Writes to read-only places must leave the reset values untouched.
    row_s rows [10] = '{'{1'b0, 5'h06, 16'h0000, 16'h0064},
        '{1'b0, 5'h07, 16'h0000, 16'h2001}, '{1'b0, 5'h08, 16'h0000, 16'h0000},
        '{1'b0, 5'h05, 16'h0000, 16'h0000}, '{1'b0, 5'h1F, 16'h0000, 16'h0000},
        '{1'b1, 5'h06, 16'hFFFF, 16'h0064}, '{1'b1, 5'h08, 16'hFFFF, 16'h0000},
        '{1'b1, 5'h05, 16'hFFFF, 16'h0000}, '{1'b1, 5'h07, 16'hFFFF, 16'hB7FF},
        '{1'b1, 5'h07, 16'h0000, 16'h0000}};

    autoneg_next_page_regs dut (.I_CLOCK(I_CLOCK), .I_SRST(I_SRST),
        .I_REQ(I_REQ), .I_EVT(I_EVT), .O_RDATA(O_RDATA),
        .O_RVALID(O_RVALID), .O_TX_PAGE(O_TX_PAGE));
    an_partner_model lp (.i_clk(I_CLOCK), .o_evt(I_EVT));

    // Free-running 20 ns clock.
    initial begin
        I_CLOCK = 1'b0;
        forever #10 I_CLOCK = ~I_CLOCK;
    end

    // Prints the verdict and ends the run, from any caller.
    task automatic results();
        if (miscompares == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : results

    // One-cycle write strobe; writes give no answer.
    task automatic wr_reg(input logic [4:0] idx, input logic [15:0] d);
        @(negedge I_CLOCK);
        I_REQ = '{rd: 1'b0, wr: 1'b1, idx: idx, wdata: d};
        @(negedge I_CLOCK);
        I_REQ.wr = 1'b0;
    endtask : wr_reg

    // Read strobe, then check the answer half a cycle after it was taken.
    task automatic rd_chk(input logic [4:0] idx, input logic [15:0] ex);
        @(negedge I_CLOCK);
        I_REQ = '{rd: 1'b1, wr: 1'b0, idx: idx, wdata: 16'h0000};
        @(negedge I_CLOCK);
        I_REQ.rd = 1'b0;
        `CHK("rvalid", 1'b1, O_RVALID)
        `CHK("rdata", ex, O_RDATA)
    endtask : rd_chk

    // Flags are page_rx, is_base, pd_fault, lp_an_able, page_sent.
    task automatic ev(input logic [15:0] pg, input logic [4:0] f);
        lp.pulse(an_np_pkg::an_event_s'({f[4], pg, f[3:0]}));
    endtask : ev

    // Event, then autoneg_expansion_status read at the very next edge; same_cycle
    // puts the read in the event's own cycle, where the set must win.
    task automatic ev_rd(input logic [4:0] f, input logic same_cycle,
                         input logic [15:0] ex);
        fork
            ev(16'h0000, f);
            begin
                @(negedge I_CLOCK);
                if (!same_cycle) begin
                    @(negedge I_CLOCK);
                end
                I_REQ = '{rd: 1'b1, wr: 1'b0, idx: 5'h06, wdata: 16'h0000};
                @(negedge I_CLOCK);
                I_REQ.rd = 1'b0;
                `CHK("ev_rd", ex, O_RDATA)
            end
        join
    endtask : ev_rd

    // Two expansion reads on consecutive edges, each answer checked.
    task automatic rd2(input logic [15:0] ex1, input logic [15:0] ex2);
        @(negedge I_CLOCK);
        I_REQ = '{rd: 1'b1, wr: 1'b0, idx: 5'h06, wdata: 16'h0000};
        @(negedge I_CLOCK);
        `CHK("rd2_first", ex1, O_RDATA)
        @(negedge I_CLOCK);
        I_REQ.rd = 1'b0;
        `CHK("rd2_second", ex2, O_RDATA)
    endtask : rd2

    // Guards against a hang; the whole sequence needs about 96 cycles.
    initial begin
        repeat (3000) @(posedge I_CLOCK);
        miscompares++;
        results();
    end

    // Main sequence: reset, table rows, then the awkward cases.
    initial begin
        I_SRST = 1'b1;
        I_REQ = '0;
        repeat (2) @(negedge I_CLOCK);
        I_SRST = 1'b0;
        `CHK("tx_reset", 16'h2001, O_TX_PAGE)
        `CHK("rvalid_idle", 1'b0, O_RVALID)
        foreach (rows[i]) begin
            if (rows[i].wr) begin
                wr_reg(rows[i].idx, rows[i].wdata);
            end
            rd_chk(rows[i].idx, rows[i].exp);
        end
        // Toggle follows each sent page and shows on the read path too.
        wr_reg(5'h07, 16'h2001);
        ev(16'h0000, 5'b00001);
        `CHK("tx_toggle", 16'h2801, O_TX_PAGE)
        rd_chk(5'h07, 16'h2801);
        ev(16'h0000, 5'b00001);
        `CHK("tx_toggle_back", 16'h2001, O_TX_PAGE)
        // A next page lands in the receive word with its acknowledge set.
        ev(16'h9ABC, 5'b10000);
        rd_chk(5'h06, 16'h0066);
        rd_chk(5'h06, 16'h0064);
        rd_chk(5'h08, 16'hDABC);
        // A base page goes to its own store and reveals next-page ability.
        ev(16'h8001, 5'b11000);
        rd_chk(5'h05, 16'h8001);
        rd_chk(5'h06, 16'h006E);
        rd_chk(5'h08, 16'hDABC);
        ev(16'h0000, 5'b00100);
        rd_chk(5'h06, 16'h007C);
        rd_chk(5'h06, 16'h006C);
        ev(16'h0000, 5'b00010);
        rd_chk(5'h06, 16'h006D);
        rd_chk(5'h06, 16'h006D);
        // Event and read on adjacent edges, a set racing a clear, and two
        // reads in a row that must clear a flag whose cause has gone.
        ev_rd(5'b00100, 1'b0, 16'h007D);
        ev_rd(5'b00010, 1'b0, 16'h006D);
        ev_rd(5'b10000, 1'b0, 16'h006F);
        ev_rd(5'b10000, 1'b1, 16'h006D);
        rd2(16'h006F, 16'h006D);
        rd_chk(5'h08, 16'h4000);
        // Leave the transmit word and toggle away from their reset values.
        wr_reg(5'h07, 16'hFFFF);
        ev(16'h0000, 5'b00001);
        `CHK("tx_sent", 16'hBFFF, O_TX_PAGE)
        // A second reset in mid-run must restore every reset value.
        @(negedge I_CLOCK);
        I_SRST = 1'b1;
        @(negedge I_CLOCK);
        I_SRST = 1'b0;
        `CHK("tx_rereset", 16'h2001, O_TX_PAGE)
        rd_chk(5'h06, 16'h0064);
        rd_chk(5'h08, 16'h0000);
        rd_chk(5'h05, 16'h0000);
        results();
    end
endmodule : test_autoneg_next_page_regs
